// ===== hw/dmtp_pkg.sv
// Constants, field layout and types of the dual mode timer with PWM.
// Assumes one 40 MHz clock and a plain strobe register port.
`default_nettype none

package dmtp_pkg;

    localparam int unsigned AW = 3;
    localparam int unsigned DW = 16;

    // Register offsets (word index on the register port)
    localparam logic [AW-1:0] ADDR_CTRL   = 3'h0;
    localparam logic [AW-1:0] ADDR_WAVE   = 3'h1;
    localparam logic [AW-1:0] ADDR_COUNT  = 3'h2;
    localparam logic [AW-1:0] ADDR_PERIOD = 3'h3;
    localparam logic [AW-1:0] ADDR_DUTY   = 3'h4;
    localparam logic [AW-1:0] ADDR_STATUS = 3'h5;

    // Control register fields
    localparam int unsigned CTRL_ON      = 0;
    localparam int unsigned CTRL_MODE_LO = 1;
    localparam int unsigned CTRL_TRIG_LO = 3;
    localparam int unsigned CTRL_RESTART = 5;
    localparam int unsigned CTRL_SRC     = 6;
    localparam int unsigned CTRL_PS_LO   = 7;
    localparam int unsigned CTRL_IE      = 9;

    // Wave register fields
    localparam int unsigned WAVE_SEL0_LO = 0;
    localparam int unsigned WAVE_INV0    = 3;
    localparam int unsigned WAVE_SEL1_LO = 4;
    localparam int unsigned WAVE_INV1    = 7;
    localparam int unsigned WAVE_PMODE_LO = 8;
    localparam int unsigned WAVE_POE_LO  = 10;

    // Status register fields
    localparam int unsigned STAT_OVF      = 0;
    localparam int unsigned STAT_HI_OVF   = 1;
    localparam int unsigned STAT_FIRST_WV = 2;

    localparam logic [2:0]  WAVE_FIRST = 3'h0;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [7:0]  BYTE_ONE   = 8'h01;
    localparam logic [2:0]  PRE_ONE    = 3'h1;

    // Prescaler masks: divide by 1, 2, 4, 8
    localparam logic [2:0] PS_MASK0 = 3'h0;
    localparam logic [2:0] PS_MASK1 = 3'h1;
    localparam logic [2:0] PS_MASK2 = 3'h3;
    localparam logic [2:0] PS_MASK3 = 3'h7;

    typedef enum logic [1:0] {
        MODE_16   = 2'b00,
        MODE_17   = 2'b01,
        MODE_DUAL = 2'b10,
        MODE_CASC = 2'b11
    } dmtp_mode_e;

    typedef enum logic [1:0] {
        TRIG_ALWAYS = 2'b00,
        TRIG_HIGH   = 2'b01,
        TRIG_LOW    = 2'b10,
        TRIG_HALT   = 2'b11
    } dmtp_trig_e;

    typedef struct packed {
        logic             on;
        dmtp_mode_e       mode;
        dmtp_trig_e       trig;
        logic             src;
        logic [1:0]       ps;
        logic             ie;
        logic [2:0]       sel0;
        logic             inv0;
        logic [2:0]       sel1;
        logic             inv1;
        logic [1:0]       pmode;
        logic [1:0]       poe;
        logic [15:0]      period;
        logic [15:0]      duty;
        logic [15:0]      count;
        logic             down;
        logic [2:0]       pre;
        logic             wave;
        logic             ovf;
        logic             hovf;
        logic [2:0]       ext_s;
        logic [1:0]       trg_s;
        logic [DW-1:0]    rdata;
        logic             irq;
        logic [1:0]       pin;
        logic [1:0]       oe;
    } dmtp_state_s;

    localparam dmtp_state_s STATE_RESET = '0;

endpackage

`default_nettype wire

// ===== hw/dmtp_timer.sv
// Dual mode 16-bit timer with two PWM pins and a strobe register port.
// Assumes ext_tick_in and trig_in are asynchronous pins; all else on
// core_clk_in.
`default_nettype none

module dmtp_timer
    import dmtp_pkg::*;
(
    input  wire logic                  core_clk_in,  // 40 MHz clock
    input  wire logic                  rst_in,       // Sync reset, high
    input  wire logic [dmtp_pkg::AW-1:0] addr_in,    // Register index
    input  wire logic [dmtp_pkg::DW-1:0] wdata_in,   // Write data
    input  wire logic                  wr_in,        // Write strobe
    input  wire logic                  rd_in,        // Read strobe
    output logic      [dmtp_pkg::DW-1:0] rdata_out,  // Read data, next cycle
    input  wire logic                  ext_tick_in,  // External clock source
    input  wire logic                  trig_in,      // Start trigger pin
    output logic                       irq_req_out,  // Overflow request
    output logic      [1:0]            pin_out,      // PWM pin levels
    output logic      [1:0]            pin_oe_out    // PWM pin drive enable
);
    import dmtp_pkg::*;

    dmtp_state_s q;
    dmtp_state_s n;

    logic       restart;
    logic       ext_edge;
    logic       trig_ok;
    logic       src_ev;
    logic       run;
    logic       tick;
    logic [2:0] mask;
    logic       ovf_evt;
    logic       hi_evt;
    logic       clr_ovf;
    logic       clr_hovf;
    logic [1:0] wsel_ok;
    logic [1:0] inv;
    logic       en;

    always_comb begin
        n        = q;
        restart  = 1'b0;
        clr_ovf  = 1'b0;
        clr_hovf = 1'b0;
        ovf_evt  = 1'b0;
        hi_evt   = 1'b0;
        mask     = PS_MASK0;
        trig_ok  = 1'b0;
        wsel_ok  = 2'b00;
        inv      = 2'b00;
        en       = 1'b0;

        // Pin synchronisers; stage 0 feeds stage 1 only
        n.ext_s = {q.ext_s[1:0], ext_tick_in};
        n.trg_s = {q.trg_s[0], trig_in};
        ext_edge = q.ext_s[1] & ~q.ext_s[2];

        if (wr_in) begin
            unique case (addr_in)
                ADDR_CTRL: begin
                    n.on   = wdata_in[CTRL_ON];
                    n.mode = dmtp_mode_e'(wdata_in[CTRL_MODE_LO +: 2]);
                    n.trig = dmtp_trig_e'(wdata_in[CTRL_TRIG_LO +: 2]);
                    n.src  = wdata_in[CTRL_SRC];
                    n.ps   = wdata_in[CTRL_PS_LO +: 2];
                    n.ie   = wdata_in[CTRL_IE];
                    restart = wdata_in[CTRL_RESTART];
                end
                ADDR_WAVE: begin
                    n.sel0  = wdata_in[WAVE_SEL0_LO +: 3];
                    n.sel1  = wdata_in[WAVE_SEL1_LO +: 3];
                    n.inv0  = wdata_in[WAVE_INV0];
                    n.inv1  = wdata_in[WAVE_INV1];
                    n.pmode = wdata_in[WAVE_PMODE_LO +: 2];
                    n.poe   = wdata_in[WAVE_POE_LO +: 2];
                end
                ADDR_PERIOD: n.period = wdata_in;
                ADDR_DUTY:   n.duty   = wdata_in;
                ADDR_STATUS: begin
                    clr_ovf  = wdata_in[STAT_OVF];
                    clr_hovf = wdata_in[STAT_HI_OVF];
                end
                default: ;
            endcase
        end

        // working tick from source and prescaler
        unique case (q.ps)
            2'b00: mask = PS_MASK0;
            2'b01: mask = PS_MASK1;
            2'b10: mask = PS_MASK2;
            2'b11: mask = PS_MASK3;
        endcase
        src_ev = q.src ? ext_edge : 1'b1;

        // one trigger gates the whole counter
        unique case (q.trig)
            TRIG_ALWAYS: trig_ok = 1'b1;
            TRIG_HIGH:   trig_ok = q.trg_s[1];
            TRIG_LOW:    trig_ok = ~q.trg_s[1];
            TRIG_HALT:   trig_ok = 1'b0;
        endcase

        run  = q.on & trig_ok;
        tick = run & src_ev & ((q.pre & mask) == mask);
        if (run & src_ev) begin
            n.pre = q.pre + PRE_ONE;
        end

        if (tick) begin
            unique case (q.mode)
                MODE_16: begin
                    if (q.count == q.period) begin
                        n.count = CNT_ZERO;
                        ovf_evt = 1'b1;
                    end else begin
                        n.count = q.count + CNT_ONE;
                    end
                end
                MODE_17: begin
                    // turn after one held tick at period
                    if (!q.down) begin
                        if (q.count == q.period) begin
                            n.down = 1'b1;
                        end else begin
                            n.count = q.count + CNT_ONE;
                        end
                    end else if (q.count <= CNT_ONE) begin
                        n.count = CNT_ZERO;
                        n.down  = 1'b0;
                        ovf_evt = 1'b1;
                    end else begin
                        n.count = q.count - CNT_ONE;
                    end
                end
                MODE_DUAL: begin
                    if (q.count[7:0] == q.period[7:0]) begin
                        n.count[7:0] = BYTE_ZERO;
                        ovf_evt      = 1'b1;
                    end else begin
                        n.count[7:0] = q.count[7:0] + BYTE_ONE;
                    end
                    // high byte counter, own status bit
                    if (q.count[15:8] == q.period[15:8]) begin
                        n.count[15:8] = BYTE_ZERO;
                        hi_evt        = 1'b1;
                    end else begin
                        n.count[15:8] = q.count[15:8] + BYTE_ONE;
                    end
                end
                MODE_CASC: begin
                    // low match carries into high byte
                    if (q.count[7:0] == q.period[7:0]) begin
                        n.count[7:0]  = BYTE_ZERO;
                        n.count[15:8] = q.count[15:8] + BYTE_ONE;
                        ovf_evt       = 1'b1;
                    end else begin
                        n.count[7:0] = q.count[7:0] + BYTE_ONE;
                    end
                end
            endcase

            // period match wins over duty match
            if (q.count == q.period) begin
                n.wave = 1'b0;
            // wave rises as the count reaches duty
            end else if (n.count == q.duty) begin
                n.wave = 1'b1;
            end
        end

        if (restart || !q.on) begin
            n.count = CNT_ZERO;
            n.pre   = 3'h0;
            n.down  = 1'b0;
            n.wave  = 1'b0;
        end

        // sticky flags, a new event beats the clear
        n.ovf  = (q.ovf & ~clr_ovf) | ovf_evt;
        n.hovf = (q.hovf & ~clr_hovf) | hi_evt;
        n.irq  = q.ovf & q.ie;

        // Only the first waveform exists; other codes give low before inversion
        wsel_ok = {q.sel1 == WAVE_FIRST, q.sel0 == WAVE_FIRST};
        inv     = {q.inv1, q.inv0};
        for (int i = 0; i < 2; i++) begin
            // drive only with mode, enable and timer on
            en = q.on & q.pmode[i] & q.poe[i];
            n.pin[i] = en & ((wsel_ok[i] & q.wave) ^ inv[i]);
            n.oe[i]  = en;
        end

        n.rdata = '0;
        if (rd_in) begin
            unique case (addr_in)
                ADDR_CTRL: begin
                    n.rdata[CTRL_ON]            = q.on;
                    n.rdata[CTRL_MODE_LO +: 2]  = q.mode;
                    n.rdata[CTRL_TRIG_LO +: 2]  = q.trig;
                    n.rdata[CTRL_SRC]           = q.src;
                    n.rdata[CTRL_PS_LO +: 2]    = q.ps;
                    n.rdata[CTRL_IE]            = q.ie;
                end
                ADDR_WAVE: begin
                    n.rdata[WAVE_SEL0_LO +: 3]  = q.sel0;
                    n.rdata[WAVE_INV0]          = q.inv0;
                    n.rdata[WAVE_SEL1_LO +: 3]  = q.sel1;
                    n.rdata[WAVE_INV1]          = q.inv1;
                    n.rdata[WAVE_PMODE_LO +: 2] = q.pmode;
                    n.rdata[WAVE_POE_LO +: 2]   = q.poe;
                end
                ADDR_COUNT:  n.rdata = q.count;
                ADDR_PERIOD: n.rdata = q.period;
                ADDR_DUTY:   n.rdata = q.duty;
                ADDR_STATUS: begin
                    n.rdata[STAT_OVF]      = q.ovf;
                    n.rdata[STAT_HI_OVF]   = q.hovf;
                    n.rdata[STAT_FIRST_WV] = q.wave;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            q <= STATE_RESET;
        end else begin
            q <= n;
        end
    end

    assign rdata_out   = q.rdata;
    assign irq_req_out = q.irq;
    assign pin_out     = q.pin;
    assign pin_oe_out  = q.oe;

endmodule

`default_nettype wire

// ===== verification/dmtp_timer_props.sv
// Port-level checks for the dual mode timer.
// Assumes one clock domain; bound onto every dmtp_timer.
`default_nettype none
module dmtp_timer_props
    import dmtp_pkg::*;
(
    input wire logic                    core_clk_in, // Clock
    input wire logic                    rst_in,      // Sync reset
    input wire logic [dmtp_pkg::AW-1:0] addr_in,     // Index
    input wire logic [dmtp_pkg::DW-1:0] wdata_in,    // Write data
    input wire logic                    wr_in,       // Write strobe
    input wire logic                    rd_in,       // Read strobe
    input wire logic [dmtp_pkg::DW-1:0] rdata_out,   // Read data
    input wire logic                    irq_req_out, // Request
    input wire logic [1:0]              pin_out,     // Pin levels
    input wire logic [1:0]              pin_oe_out   // Drive enables
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_wr(ad);
        wr_in && addr_in == ad;
    endsequence
    sequence s_rd(ad);
        rd_in && addr_in == ad;
    endsequence
    property p_pin_undriven;
        (pin_out & ~pin_oe_out) == 2'b00;
    endproperty
    property p_off_oe;
        s_wr(ADDR_CTRL) ##0 !wdata_in[CTRL_ON] |-> ##[1:3] pin_oe_out == 2'b00;
    endproperty
    property p_wave_oe;
        s_wr(ADDR_WAVE) ##0
            !(wdata_in[WAVE_PMODE_LO] && wdata_in[WAVE_POE_LO])
            |-> ##[1:3] !pin_oe_out[0];
    endproperty
    property p_irq_mask;
        s_wr(ADDR_CTRL) ##0 !wdata_in[CTRL_IE] |-> ##2 (!irq_req_out) [*4];
    endproperty
    // Only a write may take the request down
    property p_irq_hold;
        irq_req_out && !wr_in && !$past(wr_in) |=> irq_req_out;
    endproperty
    property p_restart;
        s_wr(ADDR_CTRL) ##0 wdata_in[CTRL_RESTART] ##2 s_rd(ADDR_COUNT)
            |=> rdata_out <= 16'h0002;
    endproperty
    property p_restart_clr;
        s_rd(ADDR_CTRL) |=> !rdata_out[CTRL_RESTART];
    endproperty
    property p_flags_ro;
        s_rd(ADDR_STATUS) |=> rdata_out[15:3] == 13'h0000;
    endproperty
    a_pin_undriven: assert property (p_pin_undriven)
        else $error("pin high while released");
    a_off_oe: assert property (p_off_oe)
        else $error("pins still driven after timer off");
    a_wave_oe: assert property (p_wave_oe)
        else $error("pin driven without mode and enable");
    a_irq_mask: assert property (p_irq_mask)
        else $error("request while enable clear");
    a_irq_hold: assert property (p_irq_hold)
        else $error("request dropped without a write");
    a_restart: assert property (p_restart)
        else $error("count not restarted");
    a_restart_clr: assert property (p_restart_clr)
        else $error("restart bit reads one");
    a_flags_ro: assert property (p_flags_ro)
        else $error("unused status bits set");
endmodule
bind dmtp_timer dmtp_timer_props u_props (.core_clk_in, .rst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_req_out, .pin_out,
    .pin_oe_out);
`default_nettype wire

// ===== verification/dmtp_load.sv
// Load on the two PWM pins: pull-down pads and pulse timing of pad 0.
// Assumes levels settle before each rising core clock edge.
`default_nettype none
module dmtp_load (
    input  wire logic       core_clk_in, // Clock
    input  wire logic [1:0] pin_in,      // Driven levels
    input  wire logic [1:0] oe_in,       // Drive enables
    output logic      [1:0] pad_out,     // Pad levels
    output logic      [15:0] hi_out,     // Last high length, pad 0
    output logic      [15:0] per_out     // Last rise spacing, pad 0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] hi_q   = '0;
    logic [15:0] per_q  = '0;
    logic        prev_q = 1'b0;
    // Released pad falls to its pull-down
    assign pad_out = pin_in & oe_in;
    always @(posedge core_clk_in) begin
        prev_q <= pad_out[0];
        hi_q   <= pad_out[0] ? hi_q + 16'h0001 : 16'h0000;
        per_q  <= (pad_out[0] && !prev_q) ? 16'h0001 : per_q + 16'h0001;
        if (prev_q && !pad_out[0]) begin
            hi_out <= hi_q;
        end
        if (pad_out[0] && !prev_q) begin
            per_out <= per_q;
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_dual_mode_timer_pwm.sv
// Self-checking bench for the dual mode timer.
// Assumes the pin load and the bound checker are compiled first.
`default_nettype none
module tb_dual_mode_timer_pwm
    import dmtp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          core_clk_in = 1'b0;
    logic          rst_in      = 1'b1;
    logic [AW-1:0] addr_in     = '0;
    logic [DW-1:0] wdata_in    = '0;
    logic          wr_in       = 1'b0;
    logic          rd_in       = 1'b0;
    logic          ext_tick_in = 1'b0;
    logic          trig_in     = 1'b0;
    logic [DW-1:0] rdata_out;
    logic          irq_req_out;
    logic [1:0]    pin_out;
    logic [1:0]    pin_oe_out;
    logic [1:0]    pad;
    logic [15:0]   hi_len;
    logic [15:0]   per_len;
    logic [15:0]   v;
    logic [15:0]   a;
    logic [15:0]   p;
    logic [15:0]   d;
    int            errors = 0;
    int            comparisons = 0;
    int            cyc = 0;
    int            seed = 32'h975c;
    // Control word, trigger pin, counts per 64 cycles
    logic [15:0] rt_ctl [9] = '{16'h0021, 16'h00a1, 16'h0121, 16'h01a1,
        16'h0029, 16'h0029, 16'h0031, 16'h0039, 16'h0061};
    logic rt_trg [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
        1'b0};
    logic [15:0] rt_exp [9] = '{16'd64, 16'd32, 16'd16, 16'd8, 16'd64,
        16'd0, 16'd64, 16'd0, 16'd32};
    logic [15:0] g_ctl [4] = '{16'h0221, 16'h0223, 16'h0225, 16'h0227};
    logic [15:0] g_per [4] = '{16'h0010, 16'h000c, 16'h030e, 16'h000e};
    logic [15:0] g_exp [4] = '{16'd17, 16'd25, 16'd15, 16'd15};
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        ext_tick_in <= ~ext_tick_in;
    end
    dmtp_timer DUT (.core_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .ext_tick_in, .trig_in, .irq_req_out, .pin_out,
        .pin_oe_out);
    dmtp_load u_load (.core_clk_in, .pin_in(pin_out), .oe_in(pin_oe_out),
        .pad_out(pad), .hi_out(hi_len), .per_out(per_len));
    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Two counts of slack for synchroniser and edge alignment
    task automatic near(input logic [15:0] s, input logic [15:0] e);
        check((s + 16'd2 >= e && s <= e + 16'd2) ? e : s, e);
    endtask
    task automatic wr(input logic [AW-1:0] ad, input logic [15:0] dt);
        @(posedge core_clk_in);
        addr_in  <= ad;
        wdata_in <= dt;
        wr_in    <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] ad, output logic [15:0] dt);
        @(posedge core_clk_in);
        addr_in <= ad;
        rd_in   <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 dt = rdata_out;
    endtask
    task automatic wait_irq();
        repeat (4) @(posedge core_clk_in);
        #1;
        for (int i = 0; i < 200 && irq_req_out !== 1'b1; i++) begin
            @(posedge core_clk_in);
            #1;
        end
    endtask
    // Spacing of overflows, latency offsets cancel out
    task automatic gap(input logic [15:0] e);
        int t;
        wr(ADDR_STATUS, 16'h0003);
        wait_irq();
        t = cyc;
        wr(ADDR_STATUS, 16'h0003);
        wait_irq();
        check(16'(cyc - t), e);
    endtask
    initial begin
        repeat (20) @(posedge core_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            check(v, 16'h0000);
        end
        wr(ADDR_PERIOD, 16'hffff);
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk_in);
            trig_in <= rt_trg[i];
            wr(ADDR_CTRL, rt_ctl[i]);
            rd(ADDR_COUNT, a);
            repeat (62) @(posedge core_clk_in);
            rd(ADDR_COUNT, v);
            near(v - a, rt_exp[i]);
        end
        wr(ADDR_WAVE, 16'h0f80);
        for (int k = 0; k < 3; k++) begin
            p = 16'h0010 + 16'($random(seed) & 15);
            d = (k == 0) ? 16'h0001 : 16'h0001 + 16'($random(seed) & 7);
            wr(ADDR_PERIOD, p);
            wr(ADDR_DUTY, d);
            wr(ADDR_CTRL, 16'h0021);
            repeat (100) @(posedge core_clk_in);
            #1;
            check(per_len, p + 16'h0001);
            check(hi_len, p + 16'h0001 - d);
            check(16'(pad[1]), 16'(!pad[0]));
            check(16'(pin_oe_out), 16'h0003);
            rd(ADDR_STATUS, v);
            check(16'(v[2]), 16'(pad[0]));
        end
        wr(ADDR_WAVE, 16'h0f99);
        repeat (40) @(posedge core_clk_in);
        #1 check(16'(pad[0]), 16'h0001);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_PERIOD, g_per[m]);
            wr(ADDR_CTRL, g_ctl[m]);
            gap(g_exp[m]);
            rd(ADDR_STATUS, v);
            check(16'(v[1]), 16'(m == 2));
        end
        rd(ADDR_COUNT, v);
        check(16'(v[15:8] != 8'h00), 16'h0001);
        // Low compare 0: high byte steps every tick and passes 255
        wr(ADDR_PERIOD, 16'h0000);
        wr(ADDR_CTRL, 16'h0027);
        @(posedge core_clk_in);
        rd(ADDR_COUNT, a);
        repeat (298) @(posedge core_clk_in);
        rd(ADDR_COUNT, v);
        check(v - a, 16'h2c00);
        wr(ADDR_CTRL, 16'h0021);
        wr(ADDR_STATUS, 16'h0003);
        repeat (40) @(posedge core_clk_in);
        #1 check(16'(irq_req_out), 16'h0000);
        rd(ADDR_STATUS, v);
        check(16'(v[0]), 16'h0001);
        wr(ADDR_WAVE, 16'h0b00);
        repeat (4) @(posedge core_clk_in);
        #1 check(16'(pin_oe_out), 16'h0002);
        wr(ADDR_CTRL, 16'h0000);
        repeat (4) @(posedge core_clk_in);
        #1 check(16'(pin_oe_out), 16'h0000);
        rd(ADDR_COUNT, a);
        rd(ADDR_COUNT, v);
        check(v, a);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
